// [include/mtp_pkg.sv]
// Constants, register map and command codes for the MTP memory host controller.
// Operation
// - Host reissues an operation cut short by a hardware reset once ready.
// - High voltage on A9 with CE, OE, A6, A1 low reads maker/device code.
// - Above lockout threshold the host drives controls to avoid stray writes.
// - Writes need CE and WE low with OE high; otherwise writing is inhibited.
// - Address latches on the later falling edge, data on the earlier rising edge.
// - Secured mode entry is three writes ending with data 88 hex.
// - Array read holds CE and OE low, WE high; memory drives the word.
package mtp_pkg;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int T_ACC_NS = 120;
	localparam int T_WP_NS = 50;
	localparam int T_RP_NS = 500;
	localparam int T_RH_NS = 50;
	localparam int SYNC_LAT = 2;
	localparam int ACC_CYC = (T_ACC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + SYNC_LAT;
	localparam int WP_CYC = (T_WP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RP_CYC = (T_RP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RH_CYC = (T_RH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W = 12;

	localparam logic [4:0] OFF_CMD = 5'h00;
	localparam logic [4:0] OFF_ADDR = 5'h04;
	localparam logic [4:0] OFF_WDATA = 5'h08;
	localparam logic [4:0] OFF_RDATA = 5'h0C;
	localparam logic [4:0] OFF_STATUS = 5'h10;

	localparam int ST_BUSY = 0;
	localparam int ST_SEC = 1;
	localparam int ST_LOCK_VALID = 2;
	localparam int ST_LOCK = 3;
	localparam int ST_ERR = 4;

	localparam logic [21:0] A_UNLOCK1 = 22'h000555;
	localparam logic [21:0] A_UNLOCK2 = 22'h0002AA;
	localparam logic [15:0] D_UNLOCK1 = 16'h00AA;
	localparam logic [15:0] D_UNLOCK2 = 16'h0055;
	localparam logic [15:0] D_SEC_ENTER = 16'h0088;
	localparam logic [15:0] D_AUTOSEL = 16'h0090;
	localparam logic [15:0] D_SEC_EXIT = 16'h0000;
	localparam logic [21:0] A_ID_MFR = 22'h000000;
	localparam logic [21:0] A_ID_DEV = 22'h000001;
	localparam logic [21:0] A_ID_LOCK = 22'h000003;
	localparam logic [21:0] SEC_LAST = 22'h0001FF;
	localparam int LOCK_BIT = 7;
	localparam logic [2:0] STEP_LAST3 = 3'h2;
	localparam logic [2:0] STEP_LAST4 = 3'h3;

	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_WRITE = 3'h1,
		OP_ID_MFR = 3'h2,
		OP_ID_DEV = 3'h3,
		OP_LOCK = 3'h4,
		OP_SEC_ENTER = 3'h5,
		OP_SEC_EXIT = 3'h6,
		OP_HWRESET = 3'h7
	} mtp_op_e;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_SETUP = 3'b001,
		S_STROBE = 3'b011,
		S_HOLD = 3'b010,
		S_RST = 3'b110,
		S_RECOV = 3'b111
	} mtp_state_e;
endpackage

// [logic/mtp_host_ctrl.sv]
// Host-side controller that drives an asynchronous MTP memory from AHB-Lite registers.
`timescale 1ns/1ps
module mtp_host_ctrl (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic [21:0] mem_addr,
	output logic mem_hv_a9,
	output logic mem_ce_n,
	output logic mem_oe_n,
	output logic mem_we_n,
	output logic mem_reset_n,
	input wire logic [15:0] mem_dq_i,
	output logic [15:0] mem_dq_o,
	output logic mem_dq_oe_n
);
	typedef struct packed {
		mtp_pkg::mtp_state_e state;
		mtp_pkg::mtp_op_e op;
		logic [2:0] step;
		logic [mtp_pkg::CNT_W-1:0] cnt;
		logic busy;
		logic err;
		logic sec;
		logic lock;
		logic lock_valid;
		logic [21:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [15:0] s1;
		logic [15:0] s2;
		logic wr_pend;
		logic [4:0] wa;
		logic [31:0] hrdata;
		logic hready;
		// The response is always OKAY, but it still leaves from a flop like every output.
		logic hresp;
		logic [21:0] a;
		logic hv;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic rst_n;
		logic [15:0] dq_o;
		logic dq_oe_n;
	} mtp_st_s;

	// The memory reads array data from power-up, so reset leaves its own reset released.
	localparam mtp_st_s RESET_ST = '{state: mtp_pkg::S_IDLE, op: mtp_pkg::OP_READ,
		hready: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1, dq_oe_n: 1'b1,
		default: '0};

	mtp_st_s r;
	mtp_st_s n;
	logic [21:0] s_addr;
	logic [15:0] s_data;
	logic s_rd;
	logic s_hv;
	logic s_last;
	logic [31:0] rd_mux;
	mtp_pkg::mtp_op_e new_op;

	// Bus cycle for the current step of the running command.
	always_comb begin
		s_addr = r.addr;
		s_data = r.wdata;
		s_rd = 1'b0;
		s_hv = 1'b0;
		s_last = 1'b1;
		case (r.op)
			mtp_pkg::OP_READ: begin
				s_rd = 1'b1;
			end
			mtp_pkg::OP_WRITE: begin
				s_rd = 1'b0;
			end
			mtp_pkg::OP_ID_MFR: begin
				s_rd = 1'b1;
				s_hv = 1'b1;
				s_addr = mtp_pkg::A_ID_MFR;
			end
			mtp_pkg::OP_ID_DEV: begin
				s_rd = 1'b1;
				s_hv = 1'b1;
				s_addr = mtp_pkg::A_ID_DEV;
			end
			mtp_pkg::OP_LOCK: begin
				s_rd = 1'b1;
				s_hv = 1'b1;
				s_addr = mtp_pkg::A_ID_LOCK;
			end
			mtp_pkg::OP_SEC_ENTER, mtp_pkg::OP_SEC_EXIT: begin
				s_last = (r.op == mtp_pkg::OP_SEC_ENTER) ? (r.step == mtp_pkg::STEP_LAST3) :
					(r.step == mtp_pkg::STEP_LAST4);
				case (r.step)
					3'h0: begin
						s_addr = mtp_pkg::A_UNLOCK1;
						s_data = mtp_pkg::D_UNLOCK1;
					end
					3'h1: begin
						s_addr = mtp_pkg::A_UNLOCK2;
						s_data = mtp_pkg::D_UNLOCK2;
					end
					3'h2: begin
						s_addr = mtp_pkg::A_UNLOCK1;
						s_data = (r.op == mtp_pkg::OP_SEC_ENTER) ? mtp_pkg::D_SEC_ENTER :
							mtp_pkg::D_AUTOSEL;
					end
					default: begin
						s_addr = mtp_pkg::A_ID_MFR;
						s_data = mtp_pkg::D_SEC_EXIT;
					end
				endcase
			end
			default: begin
				s_rd = 1'b0;
			end
		endcase
	end

	always_comb begin
		rd_mux = '0;
		case (haddr[4:0])
			mtp_pkg::OFF_CMD: rd_mux = {29'h0000000, r.op};
			mtp_pkg::OFF_ADDR: rd_mux = {10'h000, r.addr};
			mtp_pkg::OFF_WDATA: rd_mux = {16'h0000, r.wdata};
			mtp_pkg::OFF_RDATA: rd_mux = {16'h0000, r.rdata};
			mtp_pkg::OFF_STATUS: begin
				rd_mux[mtp_pkg::ST_BUSY] = r.busy;
				rd_mux[mtp_pkg::ST_SEC] = r.sec;
				rd_mux[mtp_pkg::ST_LOCK_VALID] = r.lock_valid;
				rd_mux[mtp_pkg::ST_LOCK] = r.lock;
				rd_mux[mtp_pkg::ST_ERR] = r.err;
			end
			default: rd_mux = '0;
		endcase
	end

	assign new_op = mtp_pkg::mtp_op_e'(hwdata[2:0]);

	always_comb begin
		n = r;
		n.s1 = mem_dq_i;
		n.s2 = r.s1;
		n.hready = 1'b1;
		n.wr_pend = 1'b0;
		// Register writes complete in the data phase; a command while busy is dropped.
		if (r.wr_pend) begin
			case (r.wa)
				mtp_pkg::OFF_ADDR: n.addr = hwdata[21:0];
				mtp_pkg::OFF_WDATA: n.wdata = hwdata[15:0];
				mtp_pkg::OFF_CMD: begin
					if (!r.busy) begin
						n.op = new_op;
						n.step = '0;
						n.err = 1'b0;
						if (new_op == mtp_pkg::OP_HWRESET) begin
							n.busy = 1'b1;
							n.state = mtp_pkg::S_RST;
							n.cnt = mtp_pkg::CNT_W'(mtp_pkg::RP_CYC);
						end else if (new_op == mtp_pkg::OP_WRITE && r.sec && r.lock &&
							r.addr <= mtp_pkg::SEC_LAST) begin
							// A locked secured sector can never change; do not even try.
							n.err = 1'b1;
						end else begin
							n.busy = 1'b1;
							n.state = mtp_pkg::S_SETUP;
						end
					end
				end
				default: n.wr_pend = 1'b0;
			endcase
		end
		if (hsel && htrans[1] && hready) begin
			n.wr_pend = hwrite;
			n.wa = haddr[4:0];
			if (!hwrite) begin
				n.hrdata = rd_mux;
			end
		end
		case (r.state)
			mtp_pkg::S_IDLE: begin
				n.ce_n = 1'b1;
				n.oe_n = 1'b1;
				n.we_n = 1'b1;
			end
			mtp_pkg::S_SETUP: begin
				// Address, chip enable and data change in the same cycle in which the strobe falls.
				n.a = s_addr;
				n.hv = s_hv;
				n.ce_n = 1'b0;
				n.oe_n = 1'b1;
				n.we_n = 1'b1;
				n.dq_o = s_data;
				n.dq_oe_n = s_rd;
				n.state = mtp_pkg::S_STROBE;
				if (s_rd) begin
					n.oe_n = 1'b0;
					n.cnt = mtp_pkg::CNT_W'(mtp_pkg::ACC_CYC);
				end else begin
					// Write pulse is far wider than a noise glitch the memory filters out.
					n.we_n = 1'b0;
					n.cnt = mtp_pkg::CNT_W'(mtp_pkg::WP_CYC);
				end
			end
			mtp_pkg::S_STROBE: begin
				if (r.cnt != '0) begin
					n.cnt = r.cnt - 1'b1;
				end else begin
					if (s_rd) begin
						n.rdata = r.s2;
						if (r.op == mtp_pkg::OP_LOCK) begin
							n.lock = r.s2[mtp_pkg::LOCK_BIT];
							n.lock_valid = 1'b1;
						end
					end
					// WE rises while CE and data still stand, so data latches here.
					n.we_n = 1'b1;
					n.oe_n = 1'b1;
					n.state = mtp_pkg::S_HOLD;
				end
			end
			mtp_pkg::S_HOLD: begin
				n.ce_n = 1'b1;
				n.dq_oe_n = 1'b1;
				n.hv = 1'b0;
				if (s_last) begin
					n.busy = 1'b0;
					n.state = mtp_pkg::S_IDLE;
					if (r.op == mtp_pkg::OP_SEC_ENTER) begin
						n.sec = 1'b1;
					end else if (r.op == mtp_pkg::OP_SEC_EXIT) begin
						n.sec = 1'b0;
					end
				end else begin
					n.step = r.step + 1'b1;
					n.state = mtp_pkg::S_SETUP;
				end
			end
			mtp_pkg::S_RST: begin
				n.rst_n = 1'b0;
				n.ce_n = 1'b1;
				n.oe_n = 1'b1;
				n.we_n = 1'b1;
				n.dq_oe_n = 1'b1;
				n.hv = 1'b0;
				if (r.cnt != '0) begin
					n.cnt = r.cnt - 1'b1;
				end else begin
					n.rst_n = 1'b1;
					// The memory is back in array read with the normal low range mapped.
					n.sec = 1'b0;
					n.cnt = mtp_pkg::CNT_W'(mtp_pkg::RH_CYC);
					n.state = mtp_pkg::S_RECOV;
				end
			end
			mtp_pkg::S_RECOV: begin
				// Software reissues any interrupted operation after busy clears.
				if (r.cnt != '0) begin
					n.cnt = r.cnt - 1'b1;
				end else begin
					n.busy = 1'b0;
					n.state = mtp_pkg::S_IDLE;
				end
			end
			default: begin
				n.state = mtp_pkg::S_IDLE;
				n.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= RESET_ST;
		end else begin
			r <= n;
		end
	end

	assign hreadyout = r.hready;
	assign hrdata = r.hrdata;
	assign hresp = r.hresp;
	assign mem_addr = r.a;
	assign mem_hv_a9 = r.hv;
	assign mem_ce_n = r.ce_n;
	assign mem_oe_n = r.oe_n;
	assign mem_we_n = r.we_n;
	assign mem_reset_n = r.rst_n;
	assign mem_dq_o = r.dq_o;
	assign mem_dq_oe_n = r.dq_oe_n;
endmodule

// [verification/mtp_chk.sv]
// Pin-level checks on the memory side of the MTP host controller.
`timescale 1ns/1ps
module mtp_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [21:0] mem_addr,
	input wire logic mem_hv_a9,
	input wire logic mem_ce_n,
	input wire logic mem_oe_n,
	input wire logic mem_we_n,
	input wire logic mem_reset_n,
	input wire logic [15:0] mem_dq_o,
	input wire logic mem_dq_oe_n
);
	logic [7:0] rst_cnt_q;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_cnt_q <= 8'h00;
		end else begin
			rst_cnt_q <= mem_reset_n ? 8'h00 : rst_cnt_q + 8'h01;
		end
	end
	a_write_qual: assert property (!mem_we_n |-> mem_oe_n && !mem_ce_n && !mem_dq_oe_n)
		else $error("write strobe without qualifiers");
	a_read_release: assert property (!mem_oe_n |-> mem_dq_oe_n && !mem_ce_n)
		else $error("read strobe while data driven");
	// The strobe stands for the write count plus the cycle that loads it: eleven cycles.
	a_we_width: assert property ($fell(mem_we_n) |-> !mem_we_n [*8] ##1
		!mem_we_n [*3] ##1 mem_we_n)
		else $error("write pulse width");
	a_oe_width: assert property ($fell(mem_oe_n) |-> ##26 !mem_oe_n ##1 mem_oe_n)
		else $error("read pulse width");
	a_addr_hold: assert property (!mem_ce_n && !$past(mem_ce_n) |-> $stable(mem_addr))
		else $error("address moved in cycle");
	a_data_latch: assert property ($rose(mem_we_n) |->
		$stable(mem_dq_o) && !mem_ce_n ##1 mem_ce_n)
		else $error("data or select at write end");
	a_id_pins: assert property (mem_hv_a9 |->
		mem_we_n && !mem_addr[6] && mem_addr[21:2] == 20'h00000)
		else $error("id voltage with bad address");
	// The pin is low in the cycles that count down from the reset count, the loading one aside.
	a_rst_pulse: assert property ($rose(mem_reset_n) |-> rst_cnt_q == 8'(mtp_pkg::RP_CYC))
		else $error("reset pulse width");
	a_rst_quiet: assert property (!mem_reset_n |-> mem_ce_n && mem_oe_n && mem_we_n && mem_dq_oe_n)
		else $error("strobes during reset");
endmodule
bind mtp_host_ctrl mtp_chk u_mtp_chk (.hclk, .hresetn, .mem_addr, .mem_hv_a9, .mem_ce_n,
	.mem_oe_n, .mem_we_n, .mem_reset_n, .mem_dq_o, .mem_dq_oe_n);

// [verification/mtp_mem_model.sv]
// Behavioural model of the asynchronous MTP memory at the controller pins.
`timescale 1ns/1ps
module mtp_mem_model #(
	parameter logic [15:0] MFR_CODE = 16'h005A, // Arbitrary value.
	parameter logic [15:0] DEV_CODE = 16'h1234, // Arbitrary value.
	parameter bit LOCKED = 1'b1
) (
	input wire logic [21:0] mem_addr,
	input wire logic mem_hv_a9,
	input wire logic mem_ce_n,
	input wire logic mem_oe_n,
	input wire logic mem_we_n,
	input wire logic mem_reset_n,
	input wire logic [15:0] mem_dq_o,
	input wire logic mem_dq_oe_n,
	output logic [15:0] mem_dq_i
);
	logic [15:0] arr [16];
	logic [15:0] sec_arr [16];
	logic [15:0] rv, last, d;
	logic [21:0] la;
	logic [2:0] step;
	logic sec, wr_act, drv, vcc_ok;
	realtime t_fall;
	initial begin
		for (int i = 0; i < 16; i++) begin
			arr[i] = 16'hA000 + 16'(i);
			sec_arr[i] = 16'h5E00 + 16'(i * 19);
		end
		last = 16'h0000;
		// Power-up: array read, normal low range, no sequence in progress.
		sec = 1'b0;
		step = 3'h0;
		wr_act = 1'b0;
		// The supply is taken as above the lockout threshold for the whole run.
		vcc_ok = 1'b1;
	end
	always @(negedge mem_reset_n) begin
		sec = 1'b0;
		step = 3'h0;
		wr_act = 1'b0;
	end
	always @(negedge mem_we_n or negedge mem_ce_n) begin
		if (!mem_we_n && !mem_ce_n && mem_oe_n && mem_reset_n && vcc_ok) begin
			la = mem_addr;
			wr_act = 1'b1;
			t_fall = $realtime;
		end
	end
	// Only a full unlock sequence alters anything; a stray write restarts it.
	always @(posedge mem_we_n or posedge mem_ce_n) begin
		d = mem_dq_i;
		if (wr_act && $realtime - t_fall >= 5.0) begin
			if (step == 3'h4) begin
				if (!sec) arr[la[3:0]] = d;
				else if (!LOCKED) sec_arr[la[3:0]] = d;
				step = 3'h0;
			end else if (step == 3'h3) begin
				sec = (d == 16'h0000) ? 1'b0 : sec;
				step = 3'h0;
			end else if (step == 3'h2 && la[10:0] == 11'h555) begin
				sec = (d == 16'h0088) ? 1'b1 : sec;
				step = (d == 16'h0090) ? 3'h3 : (d == 16'h00A0) ? 3'h4 : 3'h0;
			end else begin
				step = (step == 3'h1 && la[10:0] == 11'h2AA && d == 16'h0055) ? 3'h2 :
					(la[10:0] == 11'h555 && d == 16'h00AA) ? 3'h1 : 3'h0;
			end
		end
		wr_act = 1'b0;
	end
	always @* begin
		drv = !mem_ce_n && !mem_oe_n && mem_we_n && mem_reset_n;
		if (mem_hv_a9 && !mem_addr[6] && !mem_addr[1]) rv = mem_addr[0] ? DEV_CODE : MFR_CODE;
		else if (mem_hv_a9) rv = {8'h00, LOCKED, 7'h08};
		else if (sec && mem_addr <= 22'h0001FF) rv = sec_arr[mem_addr[3:0]];
		else rv = arr[mem_addr[3:0]];
	end
	// A released bus shows the inverse of its last value, so stale data cannot pass.
	assign mem_dq_i = !mem_dq_oe_n ? mem_dq_o : drv ? rv : ~last;
	always @(mem_dq_i) if (!mem_dq_oe_n || drv) last = mem_dq_i;
endmodule

// [verification/mtp_host_ctrl_bench.sv]
// Self-checking bench for the MTP host controller with the memory model.
`timescale 1ns/1ps
module mtp_host_ctrl_bench;
	localparam logic [15:0] MFR = 16'h005A;
	localparam logic [15:0] DEV = 16'h1234;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, mem_hv_a9, mem_ce_n, mem_oe_n;
	logic mem_we_n, mem_reset_n, mem_dq_oe_n;
	logic [31:0] haddr, hwdata, hrdata, rd_q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [21:0] mem_addr;
	logic [15:0] mem_dq_i, mem_dq_o;
	int n_fail, num_checks, cyc;
	mtp_host_ctrl u_mtp_host_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .mem_addr, .mem_hv_a9,
		.mem_ce_n, .mem_oe_n, .mem_we_n, .mem_reset_n, .mem_dq_i, .mem_dq_o, .mem_dq_oe_n);
	mtp_mem_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_mtp_mem_model (.mem_addr, .mem_hv_a9,
		.mem_ce_n, .mem_oe_n, .mem_we_n, .mem_reset_n, .mem_dq_o, .mem_dq_oe_n, .mem_dq_i);
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic ahb(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {27'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_q = hrdata;
	endtask
	task automatic op(input logic [2:0] c, input logic [21:0] a, input logic [15:0] d);
		ahb(1'b1, mtp_pkg::OFF_ADDR, {10'h0, a});
		ahb(1'b1, mtp_pkg::OFF_WDATA, {16'h0, d});
		ahb(1'b1, mtp_pkg::OFF_CMD, {29'h0, c});
		do ahb(1'b0, mtp_pkg::OFF_STATUS, 32'h0); while (rd_q[mtp_pkg::ST_BUSY] !== 1'b0);
	endtask
	task automatic opr(input logic [2:0] c, input logic [21:0] a, input logic [15:0] exp);
		op(c, a, 16'h0000);
		ahb(1'b0, mtp_pkg::OFF_RDATA, 32'h0);
		chk(rd_q, {16'h0, exp});
	endtask
	task automatic stb(input int n, input logic exp);
		ahb(1'b0, mtp_pkg::OFF_STATUS, 32'h0);
		chk({31'h0, rd_q[n]}, {31'h0, exp});
	endtask
	task automatic t_reset;
		chk({26'h0, mem_ce_n, mem_oe_n, mem_we_n, mem_reset_n, mem_dq_oe_n, mem_hv_a9}, 32'h3E);
		chk({31'h0, hresp}, 32'h0);
		ahb(1'b1, 5'h14, 32'hFFFFFFFF);
		ahb(1'b0, 5'h14, 32'h0);
		chk(rd_q, 32'h0);
		opr(mtp_pkg::OP_READ, 22'h000002, 16'hA002);
		$display("t_reset done");
	endtask
	task automatic t_id;
		opr(mtp_pkg::OP_ID_MFR, 22'h0, MFR);
		opr(mtp_pkg::OP_ID_DEV, 22'h0, DEV);
		opr(mtp_pkg::OP_LOCK, 22'h0, 16'h0088);
		stb(mtp_pkg::ST_LOCK, 1'b1);
		$display("t_id done");
	endtask
	task automatic t_prog;
		op(mtp_pkg::OP_WRITE, 22'h000006, 16'h7777);
		opr(mtp_pkg::OP_READ, 22'h000006, 16'hA006);
		op(mtp_pkg::OP_WRITE, 22'h000555, 16'h00AA);
		op(mtp_pkg::OP_WRITE, 22'h0002AA, 16'h0055);
		op(mtp_pkg::OP_WRITE, 22'h000555, 16'h00A0);
		op(mtp_pkg::OP_WRITE, 22'h000004, 16'h1234);
		opr(mtp_pkg::OP_READ, 22'h000004, 16'h1234);
		$display("t_prog done");
	endtask
	task automatic t_sec;
		op(mtp_pkg::OP_SEC_ENTER, 22'h0, 16'h0);
		stb(mtp_pkg::ST_SEC, 1'b1);
		opr(mtp_pkg::OP_READ, 22'h000007, 16'h5E85);
		opr(mtp_pkg::OP_READ, 22'h000200, 16'hA000);
		op(mtp_pkg::OP_WRITE, 22'h0001FF, 16'h0000);
		stb(mtp_pkg::ST_ERR, 1'b1);
		op(mtp_pkg::OP_SEC_EXIT, 22'h0, 16'h0);
		stb(mtp_pkg::ST_SEC, 1'b0);
		opr(mtp_pkg::OP_READ, 22'h000000, 16'hA000);
		$display("t_sec done");
	endtask
	task automatic t_hwrst;
		op(mtp_pkg::OP_SEC_ENTER, 22'h0, 16'h0);
		op(mtp_pkg::OP_HWRESET, 22'h0, 16'h0);
		stb(mtp_pkg::ST_SEC, 1'b0);
		opr(mtp_pkg::OP_READ, 22'h000000, 16'hA000);
		$display("t_hwrst done");
	endtask
	task automatic print_verdict;
		$display("checks=%0d mismatches=%0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_id();
		t_prog();
		t_sec();
		t_hwrst();
		print_verdict();
	end
endmodule
